// *** hdl/tob_pkg.sv ***
// package: constants and carrier types of the tone output port block
`default_nettype none
package tob_pkg;
  // ************************************************************
  // register map, byte addresses
  // ************************************************************
  localparam int         ADDR_W         = 6;
  localparam logic [5:0] REG_TONE_CTRL  = 6'h00;
  localparam logic [5:0] REG_TONE_PORT  = 6'h04;
  localparam logic [5:0] REG_PORT_A     = 6'h08;
  localparam logic [5:0] REG_PORT_B     = 6'h0C;
  localparam logic [5:0] REG_BIDIR_DIR  = 6'h10;
  localparam logic [5:0] REG_BIDIR_DATA = 6'h14;
  localparam logic [5:0] REG_BIT_OP     = 6'h18;
  localparam logic [5:0] REG_HOLD_CTRL  = 6'h1C;
  localparam logic [5:0] REG_STATUS     = 6'h20;
  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int         TONE_SEL_BIT   = 3;
  localparam int         HOLD_EN_BIT    = 0;
  localparam int         STOP_OP_BIT    = 1;
  localparam int         BOP_BIT_LSB    = 0;
  localparam int         BOP_PORT_LSB   = 2;
  localparam int         BOP_OP_LSB     = 4;
  localparam int         STAT_STOP_BIT  = 0;
  localparam int         STAT_TEST_BIT  = 1;
  localparam int         STAT_TONE_BIT  = 2;
  localparam logic [3:0] TONE_CTRL_RST  = 4'h0;
  localparam logic [3:0] LATCH_RST      = 4'h0;
  localparam logic [1:0] BIDIR_PORT_SEL = 2'h3;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned TICK_HZ     = 1_000_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int          TONE_CODES  = 6;
  localparam int          HALF_W      = 9;
  localparam int unsigned TONE_HZ [TONE_CODES] = '{2000, 2200, 2500, 3000, 3500, 4000};
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {BOP_NONE, BOP_SET, BOP_CLEAR, BOP_TEST} tob_bitop_t;
  typedef enum logic {BUS_IDLE, BUS_ACK} tob_bus_state_t;
  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe;
  } tob_pins4_t;
endpackage
`default_nettype wire

// *** hdl/tob_out_port.sv ***
// module: four-bit output port latch that arms on its first write
`default_nettype none
module tob_out_port #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  output logic      [W-1:0] latch_q,
  output logic              armed_q
);
  // ************************************************************
  // checks
  // ************************************************************
  if (W != 4) begin : g_bad_w
    $error("port width must be 4");
  end

  // ************************************************************
  // latch and arm flag
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_q <= tob_pkg::LATCH_RST;
    end else if (wr_en) begin
      latch_q <= wr_data;
    end
  end

  // pin stays floating until software first writes it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (wr_en) begin
      armed_q <= 1'b1;
    end
  end

  property p_arm_on_write;
    @(posedge clk) disable iff (!rst_n)
      wr_en |=> armed_q && (latch_q == $past(wr_data));
  endproperty
  a_arm_on_write: assert property (p_arm_on_write) else $error("port not armed by write");
endmodule
`default_nettype wire

// *** hdl/tob_tone_gen.sv ***
// module: tone waveform generator with a 1 MHz tick prescaler
`default_nettype none
module tob_tone_gen #(
  parameter int TICK_CYCLES = tob_pkg::TICK_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       en,
  input  wire logic [2:0] code,
  output logic            wave_q
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic [TW-1:0]              div_q;
  logic                       tick;
  logic [tob_pkg::HALF_W-1:0] half_q;
  logic [tob_pkg::HALF_W-1:0] half_len;
  logic                       code_ok;

  // ************************************************************
  // checks
  // ************************************************************
  if (TICK_CYCLES < 1 || TICK_CYCLES > 4096) begin : g_bad_tick
    $error("tick prescale out of range");
  end

  // ************************************************************
  // prescaler
  // ************************************************************
  assign tick = (div_q == TW'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rst_n || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // ************************************************************
  // half period lookup
  // ************************************************************
  assign code_ok = (int'(code) < tob_pkg::TONE_CODES);

  always_comb begin
    half_len = '1;
    if (code_ok) begin
      half_len = tob_pkg::HALF_W'(tob_pkg::TICK_HZ / (2 * tob_pkg::TONE_HZ[code]));
    end
  end

  // ************************************************************
  // waveform
  // ************************************************************
  // >= so a shorter new code cannot run the counter past its end
  always_ff @(posedge clk) begin
    if (!rst_n || !en || !code_ok) begin
      half_q <= '0;
      wave_q <= 1'b0;
    end else if (tick) begin
      if (half_q >= half_len - 1'b1) begin
        half_q <= '0;
        wave_q <= ~wave_q;
      end else begin
        half_q <= half_q + 1'b1;
      end
    end
  end

  property p_unused_silent;
    @(posedge clk) disable iff (!rst_n)
      !code_ok |=> !wave_q;
  endproperty
  a_unused_silent: assert property (p_unused_silent) else $error("unused code made a tone");
endmodule
`default_nettype wire

// *** hdl/tob_tone_port_top.sv ***
// module: tone port, two output-only ports and bidirectional pin with register slave
`default_nettype none
module tob_tone_port_top #(
  parameter int TICK_CYCLES = tob_pkg::TICK_CYCLES
) (
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  input  wire logic [tob_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                       AVS_READ,
  input  wire logic                       AVS_WRITE,
  input  wire logic [31:0]                AVS_WRITEDATA,
  input  wire logic [3:0]                 AVS_BYTEENABLE,
  output logic      [31:0]                AVS_READDATA,
  output logic                            AVS_WAITREQUEST,
  input  wire logic                       HOLD_PIN,
  input  wire logic                       SINGLE_BIDIR_PIN_IN,
  output tob_pkg::tob_pins4_t             TONE_PORT,
  output tob_pkg::tob_pins4_t             OUTPUT_ONLY_PORT_A,
  output tob_pkg::tob_pins4_t             OUTPUT_ONLY_PORT_B,
  output logic                            SINGLE_BIDIR_PIN_OUT,
  output logic                            SINGLE_BIDIR_PIN_OE,
  output logic                            CLOCK_STOPPED
);
  localparam int NPORT = 3;

  tob_pkg::tob_bus_state_t state_q;
  tob_pkg::tob_bitop_t     bop;
  logic [31:0] rd_mux;
  logic        wr_go;
  logic [3:0]  wr_data;
  logic [1:0]  bop_port;
  logic [1:0]  bop_bit;
  logic        bop_go;
  logic        tone_wr;
  logic        tone_sel_q;
  logic [2:0]  tone_code_q;
  logic        tone_wave;
  logic        hold_en_q;
  logic        stop_q;
  logic        stop_op;
  logic        dir_q;
  logic        bidir_latch_q;
  logic        bidir_in;
  logic        test_q;
  logic [3:0]  latch   [NPORT];
  logic [3:0]  port_wd [NPORT];
  logic        port_we [NPORT];
  logic        armed   [NPORT];
  logic [5:0]  port_addr [NPORT];

  assign port_addr[0] = tob_pkg::REG_TONE_PORT;
  assign port_addr[1] = tob_pkg::REG_PORT_A;
  assign port_addr[2] = tob_pkg::REG_PORT_B;

  // ************************************************************
  // bus slave: one wait cycle, write acts on the ack edge
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q         <= tob_pkg::BUS_IDLE;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end else begin
      case (state_q)
        tob_pkg::BUS_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            state_q         <= tob_pkg::BUS_ACK;
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA    <= AVS_READ ? rd_mux : 32'h0000_0000;
          end
        end
        tob_pkg::BUS_ACK: begin
          state_q         <= tob_pkg::BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
        default: begin
          state_q         <= tob_pkg::BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
      endcase
    end
  end

  // every field sits in byte lane 0
  assign wr_go   = (state_q == tob_pkg::BUS_ACK) && AVS_WRITE && AVS_BYTEENABLE[0];
  assign wr_data = AVS_WRITEDATA[3:0];

  // clock stop blocks the input path
  assign bidir_in = SINGLE_BIDIR_PIN_IN && !stop_q;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS)
      tob_pkg::REG_TONE_CTRL:  rd_mux[3:0] = {tone_sel_q, tone_code_q};
      tob_pkg::REG_TONE_PORT:  rd_mux[3:0] = latch[0];
      tob_pkg::REG_PORT_A:     rd_mux[3:0] = latch[1];
      tob_pkg::REG_PORT_B:     rd_mux[3:0] = latch[2];
      tob_pkg::REG_BIDIR_DIR:  rd_mux[0]   = dir_q;
      tob_pkg::REG_BIDIR_DATA: rd_mux[0]   = bidir_in;
      tob_pkg::REG_HOLD_CTRL:  rd_mux[tob_pkg::HOLD_EN_BIT] = hold_en_q;
      tob_pkg::REG_STATUS: begin
        rd_mux[tob_pkg::STAT_STOP_BIT] = stop_q;
        rd_mux[tob_pkg::STAT_TEST_BIT] = test_q;
        rd_mux[tob_pkg::STAT_TONE_BIT] = tone_sel_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // single-bit operations
  // ************************************************************
  assign bop_go   = wr_go && (AVS_ADDRESS == tob_pkg::REG_BIT_OP);
  assign bop_bit  = AVS_WRITEDATA[tob_pkg::BOP_BIT_LSB +: 2];
  assign bop_port = AVS_WRITEDATA[tob_pkg::BOP_PORT_LSB +: 2];
  assign bop      = tob_pkg::tob_bitop_t'(AVS_WRITEDATA[tob_pkg::BOP_OP_LSB +: 2]);

  // the bidirectional pin has no bit addressing, so port 3 falls through
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      test_q <= 1'b0;
    end else if (bop_go && bop == tob_pkg::BOP_TEST && bop_port != tob_pkg::BIDIR_PORT_SEL) begin
      test_q <= latch[bop_port][bop_bit];
    end
  end

  // ************************************************************
  // output port latches
  // ************************************************************
  for (genvar i = 0; i < NPORT; i++) begin : g_port
    always_comb begin
      port_we[i] = 1'b0;
      port_wd[i] = latch[i];
      if (wr_go && AVS_ADDRESS == port_addr[i]) begin
        port_we[i] = 1'b1;
        port_wd[i] = wr_data;
      end else if (bop_go && bop_port == 2'(i) && bop == tob_pkg::BOP_SET) begin
        port_we[i]          = 1'b1;
        port_wd[i][bop_bit] = 1'b1;
      end else if (bop_go && bop_port == 2'(i) && bop == tob_pkg::BOP_CLEAR) begin
        port_we[i]          = 1'b1;
        port_wd[i][bop_bit] = 1'b0;
      end
    end

    tob_out_port #(
      .W(4)
    ) u_port (
      .clk     (CLK),
      .rst_n   (RST_N),
      .wr_en   (port_we[i]),
      .wr_data (port_wd[i]),
      .latch_q (latch[i]),
      .armed_q (armed[i])
    );
  end

  // ************************************************************
  // tone control
  // ************************************************************
  assign tone_wr = wr_go && (AVS_ADDRESS == tob_pkg::REG_TONE_CTRL);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tone_sel_q  <= tob_pkg::TONE_CTRL_RST[tob_pkg::TONE_SEL_BIT];
      tone_code_q <= tob_pkg::TONE_CTRL_RST[2:0];
    end else if (tone_wr) begin
      tone_sel_q  <= wr_data[tob_pkg::TONE_SEL_BIT];
      tone_code_q <= wr_data[2:0];
    end
  end

  tob_tone_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tone (
    .clk    (CLK),
    .rst_n  (RST_N),
    .en     (tone_sel_q && !stop_q),
    .code   (tone_code_q),
    .wave_q (tone_wave)
  );

  // ************************************************************
  // hold and clock stop
  // ************************************************************
  assign stop_op = wr_go && (AVS_ADDRESS == tob_pkg::REG_HOLD_CTRL)
                   && AVS_WRITEDATA[tob_pkg::STOP_OP_BIT];

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      hold_en_q <= 1'b0;
    end else if (wr_go && AVS_ADDRESS == tob_pkg::REG_HOLD_CTRL) begin
      hold_en_q <= AVS_WRITEDATA[tob_pkg::HOLD_EN_BIT];
    end
  end

  // hold high wins over a stop op in the same cycle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      stop_q <= 1'b0;
    end else if (HOLD_PIN) begin
      stop_q <= 1'b0;
    end else if (stop_op && hold_en_q) begin
      stop_q <= 1'b1;
    end
  end

  // ************************************************************
  // bidirectional pin
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dir_q         <= 1'b0;
      bidir_latch_q <= 1'b0;
    end else begin
      if (wr_go && AVS_ADDRESS == tob_pkg::REG_BIDIR_DIR) begin
        dir_q <= wr_data[0];
      end
      if (wr_go && AVS_ADDRESS == tob_pkg::REG_BIDIR_DATA) begin
        bidir_latch_q <= wr_data[0];
      end
    end
  end

  // ************************************************************
  // pin registers
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TONE_PORT            <= '0;
      OUTPUT_ONLY_PORT_A   <= '0;
      OUTPUT_ONLY_PORT_B   <= '0;
      SINGLE_BIDIR_PIN_OUT <= 1'b0;
      SINGLE_BIDIR_PIN_OE  <= 1'b0;
      CLOCK_STOPPED        <= 1'b0;
    end else begin
      // latch keeps taking writes in tone mode; only the pin ignores it
      TONE_PORT.dout[0]    <= tone_sel_q ? tone_wave : latch[0][0];
      TONE_PORT.dout[3:1]  <= latch[0][3:1];
      TONE_PORT.oe         <= (armed[0] && !stop_q) ? 4'hF : 4'h0;
      OUTPUT_ONLY_PORT_A   <= '{dout: latch[1], oe: (armed[1] && !stop_q) ? 4'hF : 4'h0};
      OUTPUT_ONLY_PORT_B   <= '{dout: latch[2], oe: (armed[2] && !stop_q) ? 4'hF : 4'h0};
      SINGLE_BIDIR_PIN_OUT <= bidir_latch_q;
      SINGLE_BIDIR_PIN_OE  <= dir_q && !stop_q;
      CLOCK_STOPPED        <= stop_q;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_sel_clear;
    tone_wr && !wr_data[tob_pkg::TONE_SEL_BIT];
  endsequence
  property p_sel_clear;
    @(posedge CLK) disable iff (!RST_N)
      s_sel_clear ##1 !tone_wr |=> (TONE_PORT.dout[0] == $past(latch[0][0]));
  endproperty
  a_sel_clear: assert property (p_sel_clear) else $error("pin 0 not latch after select clear");

  property p_tone_route;
    @(posedge CLK) disable iff (!RST_N)
      tone_sel_q |=> (TONE_PORT.dout[0] == $past(tone_wave));
  endproperty
  a_tone_route: assert property (p_tone_route) else $error("tone not on pin 0");

  property p_code_load;
    @(posedge CLK) disable iff (!RST_N)
      tone_wr |=> (tone_code_q == $past(AVS_WRITEDATA[2:0])) ##1 (tone_wr || $stable(tone_code_q));
  endproperty
  a_code_load: assert property (p_code_load) else $error("tone code not loaded or held");

  property p_upper_pins;
    @(posedge CLK) disable iff (!RST_N)
      !$past(!RST_N) |-> (TONE_PORT.dout[3:1] == $past(latch[0][3:1]));
  endproperty
  a_upper_pins: assert property (p_upper_pins) else $error("tone reached pins 1 to 3");

  property p_stop_float;
    @(posedge CLK) disable iff (!RST_N)
      stop_q |=> (TONE_PORT.oe == 4'h0) && (OUTPUT_ONLY_PORT_A.oe == 4'h0)
                 && (OUTPUT_ONLY_PORT_B.oe == 4'h0) && !SINGLE_BIDIR_PIN_OE;
  endproperty
  a_stop_float: assert property (p_stop_float) else $error("pins driven in clock stop");

  property p_float_until_write;
    @(posedge CLK) disable iff (!RST_N)
      (OUTPUT_ONLY_PORT_A.oe != 4'h0) |-> $past(armed[1]) && !$past(stop_q);
  endproperty
  a_float_until_write: assert property (p_float_until_write) else $error("port drove early");

  property p_dir_drive;
    @(posedge CLK) disable iff (!RST_N)
      SINGLE_BIDIR_PIN_OE |-> $past(dir_q) && !$past(stop_q);
  endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("bidir driven as input");

  property p_bitop_bidir;
    @(posedge CLK) disable iff (!RST_N)
      bop_go && bop_port == tob_pkg::BIDIR_PORT_SEL |=> $stable(bidir_latch_q) && $stable(test_q);
  endproperty
  a_bitop_bidir: assert property (p_bitop_bidir) else $error("bit op touched bidir");

  sequence s_stop_read;
    state_q == tob_pkg::BUS_IDLE && AVS_READ && AVS_ADDRESS == tob_pkg::REG_BIDIR_DATA && stop_q;
  endsequence
  property p_stop_input;
    @(posedge CLK) disable iff (!RST_N)
      s_stop_read |=> !AVS_WAITREQUEST && !AVS_READDATA[0];
  endproperty
  a_stop_input: assert property (p_stop_input) else $error("bidir input live in stop");

  property p_reset_input;
    @(posedge CLK)
      !RST_N |=> !SINGLE_BIDIR_PIN_OE && !dir_q;
  endproperty
  a_reset_input: assert property (p_reset_input) else $error("bidir not input after reset");

  sequence s_stop_req;
    stop_op && hold_en_q && !HOLD_PIN;
  endsequence
  property p_stop_enter;
    @(posedge CLK) disable iff (!RST_N)
      s_stop_req |=> stop_q ##1 (CLOCK_STOPPED || $past(HOLD_PIN));
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("clock stop not entered");

  property p_stop_exit;
    @(posedge CLK) disable iff (!RST_N)
      HOLD_PIN || (stop_op && !hold_en_q) |=> !stop_q || $past(stop_q);
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("clock stop wrongly entered");
endmodule
`default_nettype wire

// *** testbench/tob_pin_model.sv ***
// model: beeper on tone pin 0 and far end of the bidirectional pin
`default_nettype none
module tob_pin_model (
  input  wire logic clk,
  input  wire logic tone_dout,
  input  wire logic tone_oe,
  input  wire logic bidir_out,
  input  wire logic bidir_oe,
  input  wire logic ext_en,
  input  wire logic ext_val,
  output logic      pin_in,
  output int        beeps
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_q = 1'b0;
  logic prev_q = 1'b0;
  initial beeps = 0;
  // floating wire: inverse of last level, never a stale copy
  always_comb pin_in = bidir_oe ? bidir_out : (ext_en ? ext_val : ~last_q);
  // beeper counts edges only while the pin is driven
  always @(posedge clk) begin
    last_q <= pin_in;
    prev_q <= tone_dout;
    if (tone_oe && tone_dout != prev_q) beeps <= beeps + 1;
  end
endmodule
`default_nettype wire

// *** testbench/tone_output_port_block_tb_top.sv ***
// testbench: directed scenarios for the tone output port block
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module tone_output_port_block_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // harness
  // ************************************************************
  logic                clk, rst_n, rd, wr, wq, hold, ext_en, ext_val, pin_in, bo, boe, stp;
  logic [5:0]          ad;
  logic [31:0]         wd, rdata, r;
  tob_pkg::tob_pins4_t tp, pa, pb;
  int                  beeps, b0, prev, err_total, num_checks;
  // tick shrunk to 2 cycles so tones fit a short run
  tob_tone_port_top #(.TICK_CYCLES(2)) dut_u (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(ad),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq), .HOLD_PIN(hold),
    .SINGLE_BIDIR_PIN_IN(pin_in), .TONE_PORT(tp), .OUTPUT_ONLY_PORT_A(pa),
    .OUTPUT_ONLY_PORT_B(pb), .SINGLE_BIDIR_PIN_OUT(bo), .SINGLE_BIDIR_PIN_OE(boe),
    .CLOCK_STOPPED(stp));
  tob_pin_model pm_u (.clk(clk), .tone_dout(tp.dout[0]), .tone_oe(tp.oe[0]),
    .bidir_out(bo), .bidir_oe(boe), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in), .beeps(beeps));
  // no local limit: the watchdog ends a hung handshake
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
    end while (wq !== 1'b0);
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    `CHK("tone oe", 4'h0, tp.oe)
    `CHK("bidir oe", 1'b0, boe)
    bus(0, tob_pkg::REG_BIDIR_DATA, 0);
    `CHK("bidir in", 32'h1, r)
  endtask
  task automatic t_ports();
    bus(1, tob_pkg::REG_PORT_A, 32'h5);
    wt(2);
    `CHK("port a", 8'h5F, pa)
    `CHK("port b oe", 4'h0, pb.oe)
    bus(1, tob_pkg::REG_PORT_B, 32'hA);
    bus(1, tob_pkg::REG_TONE_PORT, 32'h6);
    wt(2);
    `CHK("port b", 8'hAF, pb)
    `CHK("tone port", 8'h6F, tp)
  endtask
  task automatic t_tone();
    prev = 0;
    bus(1, tob_pkg::REG_TONE_PORT, 32'hF);
    for (int c = 0; c < 8; c++) begin
      bus(1, tob_pkg::REG_TONE_CTRL, 32'h8 | c);
      bus(0, tob_pkg::REG_TONE_CTRL, 0);
      `CHK("tone ctrl", 32'h8 | c, r)
      wt(4);
      b0 = beeps;
      wt(1200);
      `CHK("upper pins", 3'h7, tp.dout[3:1])
      if (c < 6) begin
        `CHK("tone ascends", 1'b1, beeps - b0 >= prev && beeps - b0 >= 2)
        prev = beeps - b0;
      end else begin
        `CHK("silent code", 1'b0, tp.dout[0] | (beeps != b0))
      end
    end
    bus(1, tob_pkg::REG_TONE_CTRL, 32'h9);
    wt(4);
    b0 = beeps;
    bus(1, tob_pkg::REG_TONE_PORT, 32'h0);
    bus(0, tob_pkg::REG_TONE_PORT, 0);
    `CHK("tone latch", 32'h0, r)
    wt(1000);
    `CHK("tone on", 1'b1, beeps - b0 >= 2)
    `CHK("upper low", 3'h0, tp.dout[3:1])
    bus(1, tob_pkg::REG_TONE_CTRL, 32'h1);
    wt(4);
    b0 = beeps;
    wt(600);
    `CHK("latch pin", 2'h0, {tp.dout[0], beeps != b0})
    // a high latch bit proves the pin follows the latch again
    bus(1, tob_pkg::REG_TONE_PORT, 32'h1);
    wt(2);
    `CHK("latch pin high", 1'b1, tp.dout[0])
  endtask
  task automatic t_bidir();
    bus(1, tob_pkg::REG_BIDIR_DATA, 32'h1);
    wt(2);
    `CHK("still input", 1'b0, boe)
    @(posedge clk);
    ext_en <= 1'b0;
    bus(1, tob_pkg::REG_BIDIR_DIR, 32'h1);
    wt(2);
    `CHK("bidir drive", 2'h3, {boe, bo})
    bus(1, tob_pkg::REG_BIT_OP, 32'h2C);
    wt(2);
    `CHK("clear ignored", 1'b1, bo)
    bus(1, tob_pkg::REG_BIDIR_DATA, 32'h0);
    bus(1, tob_pkg::REG_BIT_OP, 32'h1C);
    wt(2);
    `CHK("set ignored", 1'b0, bo)
    bus(0, tob_pkg::REG_BIDIR_DATA, 0);
    `CHK("bidir read", 32'h0, r)
    // set tone latch bit 2, test it, then a test on the bidir pin must not clobber it
    bus(1, tob_pkg::REG_BIT_OP, 32'h12);
    bus(1, tob_pkg::REG_BIT_OP, 32'h32);
    bus(1, tob_pkg::REG_BIT_OP, 32'h3C);
    bus(0, tob_pkg::REG_STATUS, 0);
    `CHK("test ignored", 32'h2, r)
  endtask
  task automatic t_stop();
    bus(1, tob_pkg::REG_HOLD_CTRL, 32'h1);
    bus(1, tob_pkg::REG_HOLD_CTRL, 32'h3);
    wt(3);
    `CHK("hold high blocks", 1'b0, stp)
    @(posedge clk);
    hold <= 1'b0;
    bus(1, tob_pkg::REG_HOLD_CTRL, 32'h3);
    wt(3);
    `CHK("stopped", 1'b1, stp)
    `CHK("ports float", 12'h0, {tp.oe, pa.oe, pb.oe})
    `CHK("bidir float", 1'b0, boe)
    @(posedge clk);
    ext_en <= 1'b1;
    ext_val <= 1'b1;
    bus(0, tob_pkg::REG_BIDIR_DATA, 0);
    `CHK("input off", 32'h0, r)
    @(posedge clk);
    hold <= 1'b1;
    wt(3);
    `CHK("resumed", 9'h05F, {stp, pa})
  endtask
  // second reset mid-run: armed ports and bidir direction must fall back
  task automatic t_rearm();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wt(1);
    `CHK("rearm float", 12'h0, {tp.oe, pa.oe, pb.oe})
    `CHK("rearm input", 1'b0, boe)
  endtask
  // ************************************************************
  // run control
  // ************************************************************
  task automatic conclude();
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // about 11.4k cycles expected; limit leaves ample margin
  initial begin
    #400000;
    err_total++;
    $display("Error watchdog exp done got hang");
    conclude();
  end
  initial begin
    {rst_n, rd, wr, ad, wd} = '0;
    {hold, ext_en, ext_val} = 3'h7;
    err_total = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wt(1);
    t_reset();
    t_ports();
    t_tone();
    t_bidir();
    t_stop();
    t_rearm();
    conclude();
  end
endmodule
`default_nettype wire
